// ### pkg/exec_subset_pkg.sv
// constants for the instruction execute subset
`default_nettype none
package exec_subset_pkg;
    // opcode patterns (upper bits of word)
    localparam logic [5:0]  OPC_XOR_WORK_FILE   = 6'h06;  // 0001 10da
    localparam logic [5:0]  OPC_ROT_LEFT_NC     = 6'h11;  // 0100 01da
    localparam logic [5:0]  OPC_ROT_RIGHT_C     = 6'h0C;  // 0011 00da
    localparam logic [7:0]  OPC_BRANCH_NOT_NEG  = 8'hE7;  // 1110 0111
    localparam logic [15:0] OPC_CALL_WORK       = 16'h0014;
    localparam logic [8:0]  OPC_MOVE_INDEXED    = 9'h1D6; // 1110 1011 0
    localparam logic [7:0]  ACCESS_LIMIT        = 8'h5F;
    localparam logic [11:0] ACCESS_SFR_BASE     = 12'hF00;
    localparam logic [7:0]  ACCESS_SPLIT        = 8'h60;
    // addresses of indirect data registers (the ones that read as zero when moved)
    localparam logic [11:0] INDF0_ADDR          = 12'hFEF;
    localparam logic [11:0] INDF1_ADDR          = 12'hFE7;
    localparam logic [11:0] INDF2_ADDR          = 12'hFDF;
    localparam logic [3:0]  IND_LOW_FIRST       = 4'hB;
    localparam logic [3:0]  IND_LOW_LAST        = 4'hF;
    localparam logic [20:0] PC_STEP             = 21'h000002;
    localparam logic [20:0] PC_RESET            = 21'h000000;
    localparam logic [7:0]  BYTE_RESET          = 8'h00;
    localparam logic [1:0]  PHASE_LAST          = 2'h3;

    typedef enum logic [1:0]
    {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } phase_e;

    typedef enum logic [1:0]
    {
        CY_FIRST   = 2'b00,
        CY_FLUSH   = 2'b01,
        CY_MOVE2   = 2'b10
    } cycle_e;
endpackage
`default_nettype wire

// ### src/exec_subset.sv
// execution of a subset of an 8-bit core's instructions over a four-phase cycle
//
// Summary of operation
// RL1: xor working register with file register; only negative and zero flags change.
// RL2: destination bit 0 sends result to working register, 1 to the file register.
// RL3: access bit 0 selects access bank, 1 lets bank select choose the bank.
// RL4: access bit 0, extended set on, address up to 95 gives indexed literal offset.
// RL5: call via working register pushes program counter plus two on the stack.
// RL6: pc low byte from working register; high and upper from the latches.
// RL7: call via working register takes two cycles, second is a no-operation.
// RL8: call leaves working register, flags and bank select untouched; single word.
// RL9: indexed move source is 7-bit offset plus indirect pointer two.
// RL10: indexed move destination is 12-bit literal of the second word.
// RL11: software never names pc low or stack top bytes as move destination.
// RL12: source hitting an indirect register yields zero as moved value.
// RL13: indexed move takes two words, two cycles; dummy read then write.
// RL14: branch if not negative adds twice offset when negative clear, two cycles.
// RL15: rotate left without carry: bit 7 into bit 0; negative and zero only.
// RL16: rotate right through carry: bit 0 to carry, carry to bit 7.
// RL17: each cycle runs decode, read, process and write phases.
`default_nettype none
module exec_subset
    import exec_subset_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic [7:0]  pc_high_latch_i,
    input  wire logic [7:0]  pc_upper_latch_i,
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic [11:0] indirect_pointer_two_i,
    output logic      [20:0] pc_o,
    output logic      [1:0]  phase_o,
    output logic      [11:0] file_addr_o,
    output logic             file_rd_o,
    output logic      [7:0]  file_wdata_o,
    output logic             file_we_o,
    output logic      [20:0] stack_push_data_o,
    output logic             stack_push_o,
    output logic      [7:0]  working_register_o,
    output logic             flag_carry_o,
    output logic             flag_zero_o,
    output logic             flag_negative_o,
    output logic             fetch_o,
    output logic             unknown_instr_o
);

    typedef struct packed
    {
        phase_e      phase;
        cycle_e      cyc;
        logic [15:0] ir;
        logic [20:0] pc;
        logic [11:0] addr;
        logic        rd;
        logic        we;
        logic [7:0]  wdata;
        logic [7:0]  opnd;
        logic [7:0]  result;
        logic [7:0]  move_val;
        logic [20:0] push_data;
        logic        push;
        logic [7:0]  working_register;
        logic        carry;
        logic        zero;
        logic        negative;
        logic        fetch;
        logic        unknown;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    logic        is_xor;
    logic        is_rlnc;
    logic        is_rrc;
    logic        is_bnn;
    logic        is_call_via_work_reg;
    logic        is_move;
    logic        is_file_op;
    logic [11:0] file_addr;
    logic [11:0] move_src;
    logic        src_indirect;
    logic [7:0]  alu_out;
    logic        alu_carry;

    always_comb
    begin
        is_xor     = (st_r.ir[15:10] == OPC_XOR_WORK_FILE);   // RL1
        is_rlnc    = (st_r.ir[15:10] == OPC_ROT_LEFT_NC);     // RL15
        is_rrc     = (st_r.ir[15:10] == OPC_ROT_RIGHT_C);     // RL16
        is_bnn     = (st_r.ir[15:8] == OPC_BRANCH_NOT_NEG);   // RL14
        is_call_via_work_reg   = (st_r.ir == OPC_CALL_WORK);              // RL8
        is_move    = (st_r.ir[15:7] == OPC_MOVE_INDEXED);
        is_file_op = is_xor || is_rlnc || is_rrc;
        // bank and access addressing of byte-oriented file operands
        if (st_r.ir[8])
        begin
            file_addr = {bank_select_register_i, st_r.ir[7:0]};  // RL3
        end
        else if (ext_set_en_i && (st_r.ir[7:0] <= ACCESS_LIMIT))
        begin
            file_addr = indirect_pointer_two_i + {4'h0, st_r.ir[7:0]};  // RL4
        end
        else if (st_r.ir[7:0] < ACCESS_SPLIT)
        begin
            file_addr = {4'h0, st_r.ir[7:0]};  // RL3
        end
        else
        begin
            file_addr = ACCESS_SFR_BASE | {4'h0, st_r.ir[7:0]};  // RL3
        end
        move_src = indirect_pointer_two_i + {5'h00, st_r.ir[6:0]};  // RL9

        // indirect data registers sit in two rows: low nibbles B..F in both, 3..7 as well in the upper row;
        // a move whose source lands on one of them hands over zero instead of the pointed-to byte
        src_indirect = 1'b0;
        if (st_r.addr[11:4] == INDF2_ADDR[11:4] && st_r.addr[3:0] >= IND_LOW_FIRST)
        begin
            src_indirect = 1'b1;  // RL12
        end
        else if (st_r.addr[11:4] == INDF0_ADDR[11:4] && {1'b1, st_r.addr[2:0]} >= IND_LOW_FIRST)
        begin
            src_indirect = 1'b1;  // RL12
        end
        // xor and the left rotate pass the carry through untouched
        alu_out   = st_r.opnd;
        alu_carry = st_r.carry;
        if (is_xor)
        begin
            alu_out = st_r.working_register ^ st_r.opnd;  // RL1
        end
        else if (is_rlnc)
        begin
            alu_out = {st_r.opnd[6:0], st_r.opnd[7]};  // RL15
        end
        else if (is_rrc)
        begin
            alu_out   = {st_r.carry, st_r.opnd[7:1]};  // RL16
            alu_carry = st_r.opnd[0];                 // RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer and execution

    always_comb
    begin
        st_nxt       = st_r;
        // strobes are one-clock pulses: cleared here, raised only in the phase that owns them
        st_nxt.rd    = 1'b0;
        st_nxt.we    = 1'b0;
        st_nxt.push  = 1'b0;
        st_nxt.fetch = 1'b0;
        st_nxt.phase = phase_e'(st_r.phase + 2'h1);  // RL17
        case (st_r.phase)
            PH_DECODE:
            begin
                if (st_r.cyc == CY_FIRST)
                begin
                    st_nxt.unknown = !(is_file_op || is_bnn || is_call_via_work_reg || is_move);
                end
            end
            PH_READ:
            begin
                if (st_r.cyc == CY_FIRST && is_file_op)
                begin
                    st_nxt.addr = file_addr;  // RL17
                    st_nxt.rd   = 1'b1;
                end
                else if (st_r.cyc == CY_FIRST && is_move)
                begin
                    st_nxt.addr = move_src;  // RL9
                end
                else if (st_r.cyc == CY_MOVE2)
                begin
                    // second cycle: dummy read of the destination before it is written
                    st_nxt.addr = st_r.ir[11:0];  // RL10
                    st_nxt.rd   = 1'b1;          // RL13
                end
            end
            PH_PROCESS:
            begin
                if (st_r.cyc == CY_FIRST && is_file_op)
                begin
                    // read data is taken while the read strobe still stands
                    st_nxt.opnd = file_rdata_i;
                end
                else if (st_r.cyc == CY_FIRST && is_call_via_work_reg)
                begin
                    st_nxt.push_data = st_r.pc + PC_STEP;  // RL5
                    st_nxt.push      = 1'b1;               // RL5
                end
                else if (st_r.cyc == CY_FIRST && is_move)
                begin
                    st_nxt.rd = 1'b1;  // RL13
                end
            end
            default:
            begin
                // every cycle ends in a fetch; taken branches and calls put the old word back below
                st_nxt.fetch = 1'b1;
                st_nxt.ir    = instr_i;
                st_nxt.cyc   = CY_FIRST;
                st_nxt.pc    = st_r.pc + PC_STEP;
                if (st_r.cyc == CY_FIRST && is_file_op)
                begin
                    st_nxt.result   = alu_out;
                    st_nxt.zero     = (alu_out == BYTE_RESET);  // RL1
                    st_nxt.negative = alu_out[7];               // RL1
                    st_nxt.carry    = alu_carry;                // RL16
                    if (st_r.ir[9])
                    begin
                        st_nxt.wdata = alu_out;  // RL2
                        st_nxt.we    = 1'b1;     // RL2
                    end
                    else
                    begin
                        st_nxt.working_register = alu_out;  // RL2
                    end
                end
                else if (st_r.cyc == CY_FIRST && is_bnn && !st_r.negative)
                begin
                    // incremented pc plus twice the signed offset
                    st_nxt.pc  = st_r.pc + PC_STEP + {{12{st_r.ir[7]}}, st_r.ir[7:0], 1'b0};  // RL14
                    st_nxt.cyc = CY_FLUSH;  // RL14
                    st_nxt.ir  = st_r.ir;
                end
                else if (st_r.cyc == CY_FIRST && is_call_via_work_reg)
                begin
                    // the word fetched in this cycle is dropped; the flush cycle fetches at the target
                    st_nxt.pc  = {pc_upper_latch_i[4:0], pc_high_latch_i, st_r.working_register};  // RL6
                    st_nxt.cyc = CY_FLUSH;  // RL7
                    st_nxt.ir  = st_r.ir;
                end
                else if (st_r.cyc == CY_FIRST && is_move)
                begin
                    // source value latched; indirect registers read as zero
                    if (src_indirect)
                    begin
                        st_nxt.move_val = BYTE_RESET;  // RL12
                    end
                    else
                    begin
                        st_nxt.move_val = file_rdata_i;
                    end
                    st_nxt.cyc = CY_MOVE2;  // RL13
                end
                else if (st_r.cyc == CY_MOVE2)
                begin
                    st_nxt.wdata = st_r.move_val;  // RL13
                    st_nxt.we    = 1'b1;           // RL13
                end
                // flush cycles of a taken branch or call hold the pc instead of advancing it
                if (st_r.cyc == CY_FLUSH)
                begin
                    st_nxt.pc = st_r.pc;  // RL7
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r       <= '0;
            st_r.phase <= PH_DECODE;
            // start in a flush cycle so nothing executes before the first word is fetched
            st_r.cyc   <= CY_FLUSH;
            st_r.pc    <= PC_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from state

    assign pc_o               = st_r.pc;
    assign phase_o            = st_r.phase;
    assign file_addr_o        = st_r.addr;
    assign file_rd_o          = st_r.rd;
    assign file_wdata_o       = st_r.wdata;
    assign file_we_o          = st_r.we;
    assign stack_push_data_o  = st_r.push_data;
    assign stack_push_o       = st_r.push;
    assign working_register_o = st_r.working_register;
    assign flag_carry_o       = st_r.carry;
    assign flag_zero_o        = st_r.zero;
    assign flag_negative_o    = st_r.negative;
    assign fetch_o            = st_r.fetch;
    assign unknown_instr_o    = st_r.unknown;

endmodule // exec_subset
`default_nettype wire

// ### bench/exec_subset_checker.sv
// port assertions for the execute subset
`default_nettype none
module exec_subset_checker
    import exec_subset_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  pc_high_latch_i,
    input wire logic [7:0]  pc_upper_latch_i,
    input wire logic [20:0] pc_o,
    input wire logic [1:0]  phase_o,
    input wire logic        file_rd_o,
    input wire logic        file_we_o,
    input wire logic [20:0] stack_push_data_o,
    input wire logic        stack_push_o,
    input wire logic [7:0]  working_register_o,
    input wire logic        flag_carry_o,
    input wire logic        flag_zero_o,
    input wire logic        flag_negative_o,
    input wire logic        fetch_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // two cycles of history so the first phase after release is not judged
    a_phase_step: assert property (!$past(sys_rst_i, 2) |-> phase_o == $past(phase_o) + 2'h1)
        else $error("phase did not step");
    a_read_phase: assert property (file_rd_o |-> phase_o inside {PH_PROCESS, PH_WRITE})
        else $error("read outside read phase");
    a_fetch_decode: assert property (fetch_o |-> phase_o == PH_DECODE)
        else $error("fetch outside decode");
    a_fetch_gap: assert property (fetch_o |=> !fetch_o [*3])
        else $error("fetch too soon");
    a_push_addr: assert property (stack_push_o |-> stack_push_data_o == pc_o + PC_STEP)
        else $error("push data wrong");
    a_call_target: assert property (stack_push_o |-> ##[1:8]
        pc_o == {pc_upper_latch_i[4:0], pc_high_latch_i, working_register_o})
        else $error("call target wrong");
    a_call_keeps: assert property (stack_push_o |=> ($stable(working_register_o)
        && $stable({flag_carry_o, flag_zero_o, flag_negative_o})) [*5])
        else $error("call changed state");
    a_single_push: assert property (stack_push_o |=> !stack_push_o [*7])
        else $error("second push");
    a_rd_we_apart: assert property (!(file_rd_o && file_we_o))
        else $error("read and write together");
    c_push: cover property (stack_push_o);
    c_write: cover property (file_we_o);
    c_move_read: cover property (file_rd_o && phase_o == PH_WRITE);
endmodule // exec_subset_checker
bind exec_subset exec_subset_checker exec_subset_checker_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .pc_high_latch_i(pc_high_latch_i), .pc_upper_latch_i(pc_upper_latch_i), .pc_o(pc_o), .phase_o(phase_o),
    .file_rd_o(file_rd_o), .file_we_o(file_we_o), .stack_push_data_o(stack_push_data_o),
    .stack_push_o(stack_push_o), .working_register_o(working_register_o), .flag_carry_o(flag_carry_o),
    .flag_zero_o(flag_zero_o), .flag_negative_o(flag_negative_o), .fetch_o(fetch_o));
`default_nettype wire

// ### bench/data_mem_model.sv
// data memory answering the execute subset
`default_nettype none
module data_mem_model
(
    input  wire logic        sys_clk_i,
    input  wire logic [11:0] file_addr_i,
    input  wire logic        file_rd_i,
    input  wire logic [7:0]  file_wdata_i,
    input  wire logic        file_we_i,
    output logic      [7:0]  file_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    logic [7:0] last_r = 8'h00;
    // outside a read the bus shows the inverse of the last value, so a late sample is caught
    assign file_rdata_o = file_rd_i ? mem[file_addr_i] : ~last_r;
    always @(posedge sys_clk_i)
    begin
        if (file_rd_i) last_r <= mem[file_addr_i];
        if (file_we_i) mem[file_addr_i] <= file_wdata_i;
    end
endmodule // data_mem_model
`default_nettype wire

// ### bench/test_core_instruction_execute_subset.sv
// self-checking bench for the execute subset
`default_nettype none
module test_core_instruction_execute_subset
    import exec_subset_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, sys_rst_i, ext_set_en_i, d, a, hit, unknown_instr_o;
    logic        file_rd_o, file_we_o, stack_push_o, flag_carry_o, flag_zero_o, flag_negative_o, fetch_o;
    logic [15:0] instr_i;
    logic [7:0]  file_rdata_i, pc_high_latch_i, pc_upper_latch_i, working_register_o, file_wdata_o, v, res, w0, fv;
    logic [3:0]  bank_select_register_i;
    logic [11:0] indirect_pointer_two_i, file_addr_o, ad, sa;
    logic [20:0] pc_o, stack_push_data_o, fpc, tgt;
    logic [1:0]  phase_o;
    logic [31:0] rnd = 32'h000115BA;
    logic [5:0]  opc [3] = '{OPC_XOR_WORK_FILE, OPC_ROT_LEFT_NC, OPC_ROT_RIGHT_C};
    logic [7:0]  corner [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF};
    logic [11:0] ind [3] = '{INDF0_ADDR, INDF1_ADDR, INDF2_ADDR};
    int          miscompares = 0, n_checks = 0, i, op, pushes, nops;
    exec_subset exec_subset_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ext_set_en_i(ext_set_en_i),
        .instr_i(instr_i), .file_rdata_i(file_rdata_i), .pc_high_latch_i(pc_high_latch_i),
        .pc_upper_latch_i(pc_upper_latch_i), .bank_select_register_i(bank_select_register_i),
        .indirect_pointer_two_i(indirect_pointer_two_i), .pc_o(pc_o), .phase_o(phase_o), .file_addr_o(file_addr_o),
        .file_rd_o(file_rd_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
        .stack_push_data_o(stack_push_data_o), .stack_push_o(stack_push_o), .working_register_o(working_register_o),
        .flag_carry_o(flag_carry_o), .flag_zero_o(flag_zero_o), .flag_negative_o(flag_negative_o),
        .fetch_o(fetch_o), .unknown_instr_o(unknown_instr_o));
    data_mem_model data_mem_model_inst (.sys_clk_i(sys_clk_i), .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
        .file_wdata_i(file_wdata_o), .file_we_i(file_we_o), .file_rdata_o(file_rdata_i));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] roll();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction
    function automatic logic [11:0] fa(logic [7:0] f, logic ab);
        if (ab) return {bank_select_register_i, f};
        if (ext_set_en_i && f <= ACCESS_LIMIT) return indirect_pointer_two_i + {4'h0, f};
        return (f < ACCESS_SPLIT) ? {4'h0, f} : {4'hF, f};
    endfunction
    function automatic logic [7:0] expect_res(int o, logic [7:0] w, logic [7:0] f, logic c);
        if (o == 0) return w ^ f;
        if (o == 1) return {f[6:0], f[7]};
        return {c, f[7:1]};
    endfunction
    task automatic check(string what, logic [20:0] seen, logic [20:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_fetch();
        int k = 0;
        do
        begin
            @(negedge sys_clk_i);
            k++;
        end while (fetch_o !== 1'b1 && k < 40);
        if (k == 40) miscompares++;
        fpc = pc_o;
        @(posedge sys_clk_i);
    endtask
    task automatic run(logic [15:0] w1, logic [15:0] w2, logic two);
        instr_i <= w1;
        wait_fetch();
        if (two)
        begin
            instr_i <= w2; // paired second word
            wait_fetch();
        end
        instr_i <= 16'h0000;
        repeat (3) wait_fetch();
    endtask
    task automatic poll();
        hit = 0;
        pushes = 0;
        nops = 0;
        repeat (16)
        begin
            @(negedge sys_clk_i);
            hit |= (pc_o === tgt);
            pushes += (stack_push_o === 1'b1);
            nops += (unknown_instr_o === 1'b1);
        end
        @(posedge sys_clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        conclude();
    end
    initial
    begin
        {sys_rst_i, ext_set_en_i, instr_i, pc_high_latch_i, pc_upper_latch_i} = {2'b10, 32'h0000_0000};
        {bank_select_register_i, indirect_pointer_two_i} = 16'h0000;
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 16; i++)
        begin
            op = i % 3;
            v = 8'(roll() >> 24);
            void'(roll());
            ext_set_en_i <= (i < 4) | rnd[0];
            bank_select_register_i <= rnd[4:1];
            indirect_pointer_two_i <= rnd[16:5];
            fv = (i < 4) ? corner[i] : rnd[24:17];
            a = (i < 4) ? 1'b0 : rnd[25];
            d = rnd[26];
            @(posedge sys_clk_i);
            ad = fa(fv, a);
            data_mem_model_inst.mem[ad] = v;
            w0 = working_register_o;
            res = expect_res(op, w0, v, flag_carry_o);
            run({opc[op], d, a, fv}, 16'h0000, 1'b0);
            if (d) check("file result", data_mem_model_inst.mem[ad], res);
            else check("work result", working_register_o, res);
            check("negative", flag_negative_o, res[7]);
            check("zero", flag_zero_o, res == 8'h00);
            if (op == 2) check("carry", flag_carry_o, v[0]);
        end
        $display("test file operations done");
        void'(roll());
        pc_high_latch_i <= rnd[7:0];
        pc_upper_latch_i <= rnd[15:8];
        @(posedge sys_clk_i);
        w0 = working_register_o;
        tgt = {pc_upper_latch_i[4:0], pc_high_latch_i, w0};
        run(OPC_CALL_WORK, 16'h0000, 1'b0);
        tgt = 21'h000000;
        check("call keeps work", working_register_o, w0);
        instr_i <= OPC_CALL_WORK;
        wait_fetch();
        instr_i <= 16'h0000;
        tgt = {pc_upper_latch_i[4:0], pc_high_latch_i, w0};
        poll();
        check("call target", hit, 1'b1);
        check("push count", 21'(pushes), 21'h000001);
        check("call length", 21'(nops), 21'h000008);
        $display("test call done");
        for (i = 0; i < 2; i++)
        begin
            void'(roll());
            data_mem_model_inst.mem[fa(rnd[7:0], 1'b1)] = working_register_o ^ (i ? 8'h80 : 8'h01);
            run({OPC_XOR_WORK_FILE, 2'b01, rnd[7:0]}, 16'h0000, 1'b0);
            instr_i <= {OPC_BRANCH_NOT_NEG, rnd[15:8] | 8'h10};
            wait_fetch();
            instr_i <= 16'h0000;
            tgt = fpc + PC_STEP + {{12{rnd[15]}}, rnd[15:8] | 8'h10, 1'b0};
            poll();
            check("branch taken", hit, i == 0);
            check("branch length", 21'(nops), (i == 0) ? 21'h000008 : 21'h00000C);
        end
        $display("test branch done");
        for (i = 0; i < 6; i++)
        begin
            void'(roll());
            sa = (i < 3) ? {1'b0, rnd[10:0]} : ind[i-3];
            indirect_pointer_two_i <= sa - {5'h00, rnd[22:16]};
            // destinations kept clear of the program counter and stack top bytes
            ad = 12'h800 | {2'b00, rnd[31:22]};
            v = rnd[7:0] | 8'h01;
            @(posedge sys_clk_i);
            data_mem_model_inst.mem[sa] = v;
            data_mem_model_inst.mem[ad] = ~v;
            run({OPC_MOVE_INDEXED, rnd[22:16]}, {4'hF, ad}, 1'b1);
            check("moved value", data_mem_model_inst.mem[ad], (i < 3) ? v : 8'h00);
        end
        $display("test indexed move done");
        conclude();
    end
endmodule // test_core_instruction_execute_subset
`default_nettype wire
